// ==== logic/bmsd_pkg.sv ====
// Package: boot mode stream decoder constants and types
package bmsd_pkg;
  localparam int MODE_DIV = 256;
  localparam int STREAM_LEN = 256;
  localparam int CFG_W = 18;
  localparam int GAP_LSB = 15;
  localparam int DRV_LSB = 13;
  localparam int BUSW_BIT = 12;
  localparam int TMR_BIT = 11;
  localparam int WPROT_LSB = 9;
  localparam int ORDER_BIT = 8;
  localparam int MULT_LSB = 5;
  localparam int RATE_LSB = 1;
  localparam int MULT_BASE = 2;
  localparam int BEATS_64 = 4;
  localparam int BEATS_32 = 8;
  localparam logic [7:0] ADDR_CFG = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_CTRL = 8'h08;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [2:0] MULT_RSVD = 3'h7;
  localparam logic [3:0] RATE_MAX = 4'h8;
  localparam logic [1:0] WPROT_RSVD = 2'h1;
  typedef enum logic [1:0] {
    BMSD_WP_LEGACY,
    BMSD_WP_RSVD,
    BMSD_WP_PIPE,
    BMSD_WP_REISSUE
  } bmsd_wprot_t;
  typedef struct packed {
    logic [2:0] gap;
    logic [1:0] drive;
    logic bus32;
    logic timer_irq_disable;
    logic [1:0] wprot;
    logic byte_order_select;
    logic [2:0] mult;
    logic [3:0] rate;
    logic rsvd0;
  } bmsd_cfg_t;
  typedef struct packed {
    logic [3:0] group;
    logic [3:0] idle;
  } bmsd_pace_t;
endpackage : bmsd_pkg

// ==== logic/bmsd_top.sv ====
// Boot mode stream loader, field decoder, write pacer and standby control
`timescale 1ns/1ns
`default_nettype none
module bmsd_top
  import bmsd_pkg::*;
#(
  parameter int DIV = MODE_DIV,
  parameter int NBITS = STREAM_LEN
)(
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic MODE_DATA_I,
  output logic MODE_CLK_O,
  output logic CFG_DONE_O,
  input wire logic WR_START_I,
  input wire logic WR_BLOCK_I,
  output logic WR_READY_O,
  output logic WR_BEAT_O,
  output logic [2:0] DRIVE_RANK_O,
  output logic BUS32_O,
  output logic BIG_ENDIAN_O,
  output logic [1:0] WR_PROTOCOL_O,
  output logic [3:0] PLL_MULT_O,
  input wire logic HALT_EXEC_I,
  input wire logic TIMER_IRQ_I,
  input wire logic [5:0] INT_N_I,
  input wire logic NMI_N_I,
  input wire logic EXT_REQ_N_I,
  output logic [5:0] IRQ_O,
  output logic NMI_O,
  output logic EXT_REQ_O,
  output logic STANDBY_O,
  output logic CORE_CLK_EN_O,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  localparam int DW = $clog2(DIV);
  localparam int BW = $clog2(NBITS);
  initial
  begin
    if (DIV < 4 || (DIV & (DIV - 1)) != 0 || NBITS < CFG_W)
      $error("bmsd_top: unsupported DIV or NBITS");
  end

  // Block-write beat pacing: beats per group, idle cycles after it
  function automatic bmsd_pace_t pace_of(input logic [3:0] c);
    case (c)
      4'h1: pace_of = '{4'h2, 4'h1};
      4'h2: pace_of = '{4'h2, 4'h2};
      4'h3: pace_of = '{4'h1, 4'h1};
      4'h4: pace_of = '{4'h2, 4'h3};
      4'h5: pace_of = '{4'h2, 4'h4};
      4'h6: pace_of = '{4'h1, 4'h2};
      4'h7: pace_of = '{4'h2, 4'h6};
      4'h8: pace_of = '{4'h1, 4'h3};
      default: pace_of = '{4'h1, 4'h0};
    endcase
  endfunction : pace_of

  // Pin synchronisers
  logic [8:0] pin_s1_q, pin_s2_q;
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      pin_s1_q <= 9'h1FF;
      pin_s2_q <= 9'h1FF;
    end
    else
    begin
      pin_s1_q <= {MODE_DATA_I, EXT_REQ_N_I, NMI_N_I, INT_N_I};
      pin_s2_q <= pin_s1_q;
    end
  end
  logic mode_bit, ext_req, nmi;
  logic [5:0] int_lvl;
  assign mode_bit = pin_s2_q[8];
  assign ext_req = ~pin_s2_q[7];
  assign nmi = ~pin_s2_q[6];
  assign int_lvl = ~pin_s2_q[5:0];

  // Mode stream loader
  typedef enum logic {BMSD_LD_RUN, BMSD_LD_DONE} bmsd_ld_t;
  bmsd_ld_t ld_q;
  logic [DW-1:0] div_q;
  logic [BW-1:0] bit_q;
  logic [CFG_W-1:0] raw_q;
  logic rsvd_q, reload;
  bmsd_cfg_t cfg;
  assign cfg = raw_q;
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ld_q <= BMSD_LD_RUN;
      div_q <= '0;
      bit_q <= '0;
      raw_q <= '0;
      rsvd_q <= 1'b0;
    end
    else
    begin
      case (ld_q)
        BMSD_LD_RUN:
        begin
          div_q <= div_q + 1'b1;
          if (&div_q)
          begin
            bit_q <= bit_q + 1'b1;
            if (bit_q < BW'(CFG_W))
              raw_q[bit_q[$clog2(CFG_W)-1:0]] <= mode_bit;
            if ((bit_q >= BW'(CFG_W) || bit_q == '0) && mode_bit)
              rsvd_q <= 1'b1;
            if (&bit_q)
              ld_q <= BMSD_LD_DONE;
          end
        end
        BMSD_LD_DONE:
        begin
          if (reload)
          begin
            ld_q <= BMSD_LD_RUN;
            div_q <= '0;
            bit_q <= '0;
            rsvd_q <= 1'b0;
          end
        end
        default: ld_q <= BMSD_LD_DONE;
      endcase
    end
  end
  assign MODE_CLK_O = (ld_q == BMSD_LD_RUN) && div_q[DW-1];
  assign CFG_DONE_O = (ld_q == BMSD_LD_DONE);

  // Field decode
  always_comb
  begin
    case (cfg.drive)
      2'h2: DRIVE_RANK_O = 3'h3;
      2'h3: DRIVE_RANK_O = 3'h2;
      2'h0: DRIVE_RANK_O = 3'h1;
      default: DRIVE_RANK_O = 3'h0;
    endcase
  end
  assign BUS32_O = cfg.bus32;
  assign BIG_ENDIAN_O = cfg.byte_order_select;
  assign WR_PROTOCOL_O = cfg.wprot;
  assign PLL_MULT_O = (cfg.mult == MULT_RSVD) ? 4'h0 :
    4'(cfg.mult) + 4'(MULT_BASE);

  // Write pacer
  typedef enum logic [1:0] {
    BMSD_WS_IDLE, BMSD_WS_GAP, BMSD_WS_DATA, BMSD_WS_PACE
  } bmsd_ws_t;
  bmsd_ws_t ws_q;
  logic [3:0] cnt_q, beats_q, grp_q;
  logic blk_q;
  bmsd_pace_t pace;
  assign pace = pace_of(cfg.rate > RATE_MAX ? 4'h0 : cfg.rate);
  assign WR_READY_O = (ws_q == BMSD_WS_IDLE) && CFG_DONE_O && !STANDBY_O;
  assign WR_BEAT_O = (ws_q == BMSD_WS_DATA);
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ws_q <= BMSD_WS_IDLE;
      cnt_q <= '0;
      beats_q <= '0;
      grp_q <= '0;
      blk_q <= 1'b0;
    end
    else
    begin
      case (ws_q)
        BMSD_WS_IDLE:
        begin
          if (WR_START_I && WR_READY_O)
          begin
            blk_q <= WR_BLOCK_I;
            beats_q <= !WR_BLOCK_I ? 4'h1 :
              cfg.bus32 ? 4'(BEATS_32) : 4'(BEATS_64);
            grp_q <= '0;
            cnt_q <= 4'(cfg.gap);
            ws_q <= (cfg.gap == '0) ? BMSD_WS_DATA : BMSD_WS_GAP;
          end
        end
        BMSD_WS_GAP:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 4'h1)
            ws_q <= BMSD_WS_DATA;
        end
        BMSD_WS_DATA:
        begin
          beats_q <= beats_q - 1'b1;
          grp_q <= grp_q + 1'b1;
          if (beats_q == 4'h1)
            ws_q <= BMSD_WS_IDLE;
          else if (blk_q && pace.idle != '0 && grp_q + 1'b1 == pace.group)
          begin
            grp_q <= '0;
            cnt_q <= pace.idle;
            ws_q <= BMSD_WS_PACE;
          end
        end
        BMSD_WS_PACE:
        begin
          cnt_q <= cnt_q - 1'b1;
          if (cnt_q == 4'h1)
            ws_q <= BMSD_WS_DATA;
        end
        default: ws_q <= BMSD_WS_IDLE;
      endcase
    end
  end

  // Interrupt routing and standby
  logic timer_irq, wake, force_wake;
  assign timer_irq = TIMER_IRQ_I && !cfg.timer_irq_disable;
  assign IRQ_O = {int_lvl[5] | timer_irq, int_lvl[4:0]};
  assign NMI_O = nmi;
  assign EXT_REQ_O = ext_req;
  assign wake = (|IRQ_O) || nmi || force_wake;
  logic sby_q;
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sby_q <= 1'b0;
    else if (wake)
      sby_q <= 1'b0;
    else if (HALT_EXEC_I && CFG_DONE_O)
      sby_q <= 1'b1;
  end
  assign STANDBY_O = sby_q;
  assign CORE_CLK_EN_O = !sby_q;

  // AXI4-Lite slave
  logic aw_q, w_q, bv_q, rv_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q, rd_q;
  logic [1:0] br_q, rr_q;
  assign S_AXI_AWREADY = !aw_q && !bv_q;
  assign S_AXI_WREADY = !w_q && !bv_q;
  assign S_AXI_BVALID = bv_q;
  assign S_AXI_BRESP = br_q;
  assign S_AXI_ARREADY = !rv_q;
  assign S_AXI_RVALID = rv_q;
  assign S_AXI_RDATA = rd_q;
  assign S_AXI_RRESP = rr_q;
  logic aw_ok, w_ok, do_wr;
  logic [7:0] wa;
  logic [31:0] wd;
  assign aw_ok = aw_q || (S_AXI_AWVALID && S_AXI_AWREADY);
  assign w_ok = w_q || (S_AXI_WVALID && S_AXI_WREADY);
  assign do_wr = aw_ok && w_ok && !bv_q;
  assign wa = aw_q ? awa_q : S_AXI_AWADDR;
  assign wd = w_q ? wd_q : S_AXI_WDATA;
  assign reload = do_wr && wa == ADDR_CTRL && wd[0] && S_AXI_WSTRB[0];
  assign force_wake = do_wr && wa == ADDR_CTRL && wd[1] && S_AXI_WSTRB[0];
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      br_q <= RESP_OK;
    end
    else
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_q <= 1'b1;
        awa_q <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_q <= 1'b1;
        wd_q <= S_AXI_WDATA;
      end
      if (do_wr)
      begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        bv_q <= 1'b1;
        br_q <= (wa == ADDR_CTRL) ? RESP_OK : RESP_SLVERR;
      end
      else if (bv_q && S_AXI_BREADY)
        bv_q <= 1'b0;
    end
  end
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rv_q <= 1'b0;
      rd_q <= '0;
      rr_q <= RESP_OK;
    end
    else if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      rv_q <= 1'b1;
      rr_q <= RESP_OK;
      case (S_AXI_ARADDR)
        ADDR_CFG: rd_q <= 32'(raw_q);
        ADDR_STAT: rd_q <= {24'h0, (cfg.wprot == WPROT_RSVD),
          (cfg.mult == MULT_RSVD), rsvd_q, ld_q == BMSD_LD_RUN,
          (ws_q != BMSD_WS_IDLE), sby_q, CFG_DONE_O, 1'b0};
        ADDR_CTRL: rd_q <= 32'h0;
        default:
        begin
          rd_q <= 32'h0;
          rr_q <= RESP_SLVERR;
        end
      endcase
    end
    else if (rv_q && S_AXI_RREADY)
      rv_q <= 1'b0;
  end

  // Checks
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);
  zero_gap_a: assert property (WR_START_I && WR_READY_O && cfg.gap == '0
    |=> WR_BEAT_O) else $error("data not right after address");
  gap_len_a: assert property (WR_START_I && WR_READY_O && cfg.gap == 3'h3
    |=> !WR_BEAT_O [*3] ##1 WR_BEAT_O) else $error("wrong write gap");
  single_beat_a: assert property (WR_START_I && WR_READY_O && !WR_BLOCK_I
    && cfg.gap == '0 |=> WR_BEAT_O ##1 !WR_BEAT_O)
    else $error("single write beat count");
  block_pace_a: assert property (WR_BEAT_O && blk_q && cfg.rate == 4'h3
    && beats_q > 4'h1 |=> !WR_BEAT_O ##1 WR_BEAT_O)
    else $error("block pacing wrong");
  mode_clk_a: assert property ($rose(MODE_CLK_O)
    |-> $past(div_q) == DW'(DIV / 2 - 1)) else $error("mode clock rate");
  timer_mask_a: assert property (TIMER_IRQ_I && cfg.timer_irq_disable
    && !int_lvl[5] |-> !IRQ_O[5]) else $error("timer not suppressed");
  standby_in_a: assert property (HALT_EXEC_I && CFG_DONE_O && !wake
    |=> STANDBY_O && !CORE_CLK_EN_O) else $error("no standby");
  wake_a: assert property (STANDBY_O && wake |=> !STANDBY_O)
    else $error("interrupt did not wake");
  mult_a: assert property (cfg.mult != MULT_RSVD
    |-> PLL_MULT_O == 4'(cfg.mult) + 4'h2) else $error("multiplier");
  drive_a: assert property (cfg.drive == 2'h2 |-> DRIVE_RANK_O == 3'h3)
    else $error("drive rank");
  bus_w_a: assert property (BUS32_O == raw_q[BUSW_BIT])
    else $error("bus width");
  wake_pin_c: cover property (STANDBY_O ##1 !STANDBY_O);
  block_wr_c: cover property (WR_START_I && WR_READY_O && WR_BLOCK_I);
  load_done_c: cover property ($rose(CFG_DONE_O));
endmodule : bmsd_top
`default_nettype wire

// ==== bench/bmsd_mode_src.sv ====
// Serial boot mode source model
`timescale 1ns/1ns
`default_nettype none
module bmsd_mode_src
  import bmsd_pkg::*;
#(
  parameter int NBITS = STREAM_LEN
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mode_clk_i,
  input wire logic [NBITS-1:0] stream_i,
  output logic data_o
);
  int idx_q;
  logic mclk_q;
  logic tog_q;
  // Next bit after each falling shift clock, bit 0 first
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      idx_q <= 0;
      mclk_q <= 1'b0;
      tog_q <= 1'b0;
    end
    else
    begin
      mclk_q <= mode_clk_i;
      tog_q <= ~tog_q;
      if (mclk_q && !mode_clk_i)
        idx_q <= idx_q + 1;
    end
  end
  // Reserved bits come from the stream as zero; toggles once spent
  assign data_o = (idx_q < NBITS) ? stream_i[idx_q] : tog_q;
endmodule : bmsd_mode_src
`default_nettype wire

// ==== bench/tb_boot_mode_stream_decoder.sv ====
// Testbench for the boot mode stream decoder
`timescale 1ns/1ns
`default_nettype none
module tb_boot_mode_stream_decoder
  import bmsd_pkg::*;
;
  localparam int DV = 8;
  localparam int NB = 32;
  logic CLOCK_I = 1'b0;
  logic RST_N_I, MODE_DATA_I, MODE_CLK_O, CFG_DONE_O, WR_START_I, WR_BLOCK_I;
  logic WR_READY_O, WR_BEAT_O, BUS32_O, BIG_ENDIAN_O, HALT_EXEC_I, TIMER_IRQ_I;
  logic NMI_N_I, EXT_REQ_N_I, NMI_O, EXT_REQ_O, STANDBY_O, CORE_CLK_EN_O;
  logic [2:0] DRIVE_RANK_O;
  logic [1:0] WR_PROTOCOL_O, S_AXI_BRESP, S_AXI_RRESP;
  logic [3:0] PLL_MULT_O, S_AXI_WSTRB;
  logic [5:0] INT_N_I, IRQ_O;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, cfg;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  int miscompares = 0;
  int total_checks = 0;
  int grp[9] = '{0, 2, 2, 1, 2, 2, 1, 2, 1};
  int idl[9] = '{0, 1, 2, 1, 3, 4, 2, 6, 3};
  int rank_of[4] = '{1, 0, 3, 2};
  always #2 CLOCK_I = ~CLOCK_I;
  bmsd_top #(.DIV(DV), .NBITS(NB)) dut (.*);
  bmsd_mode_src #(.NBITS(NB)) src (.clk_i(CLOCK_I), .rst_n_i(RST_N_I),
    .mode_clk_i(MODE_CLK_O), .stream_i(cfg), .data_o(MODE_DATA_I));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      miscompares++;
      $display("MISMATCH %0t wait ran out", $time);
      print_verdict();
    end
  endtask : tmo
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    do
    begin
      @(posedge CLOCK_I);
      n++;
      if (S_AXI_AWVALID && S_AXI_AWREADY)
        S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY)
        S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_BVALID !== 1'b1 && n < 200);
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    @(posedge CLOCK_I);
    tmo(n);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    do
    begin
      @(posedge CLOCK_I);
      n++;
      if (S_AXI_ARVALID && S_AXI_ARREADY)
        S_AXI_ARVALID <= 1'b0;
    end
    while (S_AXI_RVALID !== 1'b1 && n < 200);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLOCK_I);
    tmo(n);
  endtask : axi_rd
  // One write; beat times counted from the edge that takes the start
  task automatic pace(input logic blk, input int gap, input int code, input logic b32);
    int t, k, nb, g;
    int exp_q[$];
    int got[$];
    nb = blk ? (b32 ? 8 : 4) : 1;
    g = blk ? grp[code] : 0;
    t = gap + 1;
    for (k = 0; k < nb; k++)
    begin
      exp_q.push_back(t);
      t++;
      if (g > 0 && (k + 1) % g == 0)
        t += idl[code];
    end
    WR_START_I <= 1'b1;
    WR_BLOCK_I <= blk;
    @(posedge CLOCK_I);
    WR_START_I <= 1'b0;
    k = 0;
    do
    begin
      @(posedge CLOCK_I);
      k++;
      if (WR_BEAT_O === 1'b1)
        got.push_back(k);
    end
    while (!(WR_READY_O === 1'b1 && k > 1) && k < 200);
    tmo(k);
    chk(got.size(), exp_q.size(), "beat count");
    foreach (exp_q[i])
      chk(got[i], exp_q[i], "beat time");
  endtask : pace
  initial
  begin
    logic [31:0] d;
    logic [1:0] r, drv, wp;
    logic [2:0] gap, mult;
    logic [3:0] rate;
    logic b32, ord, dis, odd;
    int n;
    {RST_N_I, WR_START_I, WR_BLOCK_I, HALT_EXEC_I, TIMER_IRQ_I} = '0;
    {NMI_N_I, EXT_REQ_N_I, INT_N_I, S_AXI_WSTRB} = {2'b11, 6'h3F, 4'hF};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, cfg} = '0;
    void'($urandom(21));
    for (int i = 0; i < 9; i++)
    begin
      gap = 3'(i % 8);
      mult = 3'(7 - i % 8);
      rate = 4'(i);
      drv = 2'(i);
      wp = 2'(i + 1);
      odd = i[0];
      dis = odd;
      b32 = 1'($urandom);
      ord = 1'($urandom);
      cfg = {14'h0000, gap, drv, b32, dis, wp, ord, mult, rate, 1'b0};
      RST_N_I <= 1'b0;
      repeat (4) @(posedge CLOCK_I);
      RST_N_I <= 1'b1;
      n = 0;
      while (CFG_DONE_O !== 1'b1 && n < 400)
      begin
        @(posedge CLOCK_I);
        n++;
      end
      if (n >= 400)
        tmo(200);
      chk(n >= DV * NB - 2 && n <= DV * NB + 2, 1, "load time");
      chk(DRIVE_RANK_O, rank_of[drv], "drive");
      chk(BUS32_O, b32, "width");
      chk(WR_PROTOCOL_O, wp, "protocol");
      chk(BIG_ENDIAN_O, ord, "order");
      chk(PLL_MULT_O, mult == 3'h7 ? 0 : mult + 2, "mult");
      axi_wr(ADDR_CFG, 32'hFFFF_FFFF, r);
      chk(r, RESP_SLVERR, "ro write");
      axi_rd(ADDR_CFG, d, r);
      chk({r, d[17:0]}, {RESP_OK, cfg[17:0]}, "cfg held");
      pace(1'b0, gap, 0, b32);
      pace(1'b1, gap, rate, b32);
      HALT_EXEC_I <= 1'b1;
      @(posedge CLOCK_I);
      HALT_EXEC_I <= 1'b0;
      repeat (2) @(posedge CLOCK_I);
      chk({STANDBY_O, CORE_CLK_EN_O, WR_READY_O}, 3'h4, "halt");
      TIMER_IRQ_I <= 1'b1;
      repeat (4) @(posedge CLOCK_I);
      chk({STANDBY_O, IRQ_O[5]}, {dis, ~dis}, "timer");
      TIMER_IRQ_I <= 1'b0;
      NMI_N_I <= ~odd;
      INT_N_I <= {5'h1F, odd};
      EXT_REQ_N_I <= 1'b0;
      repeat (4) @(posedge CLOCK_I);
      chk({STANDBY_O, NMI_O, IRQ_O[0], EXT_REQ_O}, {1'b0, odd, ~odd, 1'b1}, "wake");
      {NMI_N_I, EXT_REQ_N_I, INT_N_I} <= {2'b11, 6'h3F};
      repeat (4) @(posedge CLOCK_I);
    end
    HALT_EXEC_I <= 1'b1;
    @(posedge CLOCK_I);
    HALT_EXEC_I <= 1'b0;
    repeat (2) @(posedge CLOCK_I);
    axi_rd(ADDR_STAT, d, r);
    chk(r, RESP_OK, "status resp");
    chk(d, {24'h0, wp == 2'h1, mult == 3'h7, 3'h0, 1'b1, 1'b1, 1'b0}, "status");
    axi_wr(ADDR_CTRL, 32'h0000_0002, r);
    chk(r, RESP_OK, "ctrl write");
    chk(STANDBY_O, 1'b0, "force wake");
    axi_rd(8'h0C, d, r);
    chk(r, RESP_SLVERR, "unmapped resp");
    chk(d, 32'h0000_0000, "unmapped");
    print_verdict();
  end
endmodule : tb_boot_mode_stream_decoder
`default_nettype wire
